// ==== shared/lach_cfg.svh ====
`ifndef LACH_CFG_SVH
`define LACH_CFG_SVH
// frame delimiters and codes
`define LACH_CMD_START 8'h01
`define LACH_DATA_START 8'h81
`define LACH_FRAME_END 8'h03
`define LACH_CODE_AUTH 8'h30
`define LACH_CODE_ERR 8'hb0
`define LACH_LEN_CMD 16'h0004
`define LACH_LEN_RESP 16'h0021
`define LACH_LEN_CHAL 8'h11
`define LACH_LEN_STS 8'h0a
`define LACH_OK_SUM 8'hce
`define LACH_UNUSED 8'hff
// lifecycle, tier and challenge kind codes
`define LACH_LC_OWNER 8'h04
`define LACH_LC_RET_REQ 8'h07
`define LACH_LC_RET_ACK 8'h08
`define LACH_TIER_ZERO 8'h04
`define LACH_TIER_ONE 8'h03
`define LACH_TIER_TWO 8'h02
`define LACH_KIND_RANDOM 8'h00
`define LACH_KIND_UID 8'h01
// status codes
`define LACH_STS_OK 8'h00
`define LACH_STS_PACKET 8'hc1
`define LACH_STS_CHECKSUM 8'hc2
`define LACH_STS_ACCEPT 8'hc3
`define LACH_STS_UNMATCHED 8'hc4
`define LACH_STS_PARAM 8'hc5
`define LACH_STS_PROTECT 8'hc6
`define LACH_STS_TRUSTED 8'hc7
// transmit byte positions and response byte count
`define LACH_TX_PAY_FIRST 5'd4
`define LACH_TX_CHAL_SUM 5'd20
`define LACH_TX_CHAL_LAST 5'd21
`define LACH_TX_STS_SUM 5'd13
`define LACH_TX_STS_LAST 5'd14
`define LACH_RESP_BYTES 16'd32
`endif

// ==== shared/lach_pkg.sv ====
package lach_pkg;
   typedef enum logic [3:0] {
      st_idle, st_len_h, st_len_l, st_body, st_sum, st_end, st_check, st_gen, st_tx, st_auth, st_halt
   } lach_phase_type;
   typedef enum logic [1:0] {fr_chal, fr_ok, fr_err} lach_frame_type;
   typedef enum logic [1:0] {go_idle, go_resp, go_halt} lach_after_type;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } lach_byte_type;
   typedef struct packed {
      logic [7:0] active_state;
      logic [7:0] stored_state;
      logic [7:0] auth_tier;
      logic cmd_permitted;
      logic enc_write_pending;
      logic tier_one_key_en;
      logic tier_two_key_en;
   } lach_dev_type;
   typedef struct packed {
      lach_phase_type phase;
      logic resp;
      logic [15:0] len;
      logic [15:0] cnt;
      logic [7:0] code;
      logic [7:0] src;
      logic [7:0] dst;
      logic [7:0] kind;
      logic [7:0] sum;
      logic end_bad;
      logic lc_move;
      logic [127:0] chal;
      lach_frame_type frame;
      lach_after_type after;
      logic [7:0] sts;
      logic [4:0] idx;
      logic [7:0] tx_sum;
      logic [7:0] tx_data;
      logic gen_req;
      logic auth_req;
      logic trans_req;
   } lach_state_type;
endpackage

// ==== design/lach_resp_mem.sv ====
`timescale 1ns/100ps
module lach_resp_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   input wire logic core_clk,
   input wire logic we,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem_ff [DEPTH];

   always_ff @(posedge core_clk) begin
      if (we) begin
         mem_ff[wr_addr] <= wr_data;
      end
      rd_data <= mem_ff[rd_addr];
   end
endmodule // lach_resp_mem

// ==== design/lach_core.sv ====
`timescale 1ns/100ps
`include "lach_cfg.svh"
// Notes on behaviour
// [R1] host command frame: 01h, 00h 04h, 30h, source, destination, kind, check, end
// [R2] source code 04h/07h for lifecycle moves, 03h/04h for tier moves
// [R3] destination 07h/08h for lifecycle moves, 02h/03h for tier moves
// [R4] kind 00h random always valid; 01h unique id only toward return-requested
// [R5] challenge frame: 81h, 00h 11h, 30h, 16 bytes, check, 03h
// [R6] multi-byte values travel most significant byte first
// [R7] host response frame: 81h, 00h 21h, 30h, 32 bytes, check, 03h
// [R8] success status: length 0ah, code 30h, status 00h, all-ones fields, check ceh
// [R9] error status: length 0ah, code b0h, status, four-byte detail, four-byte address
// [R10] idle ignores every byte until the command start byte
// [R11] missing end byte gives packet error, highest priority
// [R12] wrong check byte gives checksum error
// [R13] length breaking format or command length gives packet error
// [R14] any error: no processing, back to command wait
// [R15] command not permitted or pending encrypted write gives acceptance error
// [R16] active and stored lifecycle state differing gives unmatched error
// [R17] source mismatch or illegal pair gives parameter error
// [R18] disabled tier keys against matching destinations give protection error
// [R19] unusable challenge kind gives parameter error after protection checks
// [R20] send challenge; generation failure trusted error; abnormal subsystem halts
// [R21] awaiting response, bytes before data start byte are discarded
// [R22] response checks: end, check, format, code, command length, in order
// [R23] check byte is negated mod-256 sum from length-high to last payload
// [R24] failed authentication gives trusted error, then command wait
// [R25] success status, then halt for lifecycle move or wait for tier move
module lach_core (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire lach_pkg::lach_byte_type rx,
   input wire logic tx_ready,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire lach_pkg::lach_dev_type dev,
   input wire logic ts_abnormal,
   output logic gen_req,
   output logic gen_uid,
   input wire logic gen_done,
   input wire logic gen_fail,
   input wire logic [127:0] gen_value,
   output logic auth_req,
   input wire logic auth_done,
   input wire logic auth_pass,
   input wire logic [4:0] auth_rd_addr,
   output logic [7:0] auth_rd_data,
   output logic trans_req,
   output logic trans_lifecycle,
   output logic [7:0] trans_dst
);
   lach_pkg::lach_state_type st_ff;
   lach_pkg::lach_state_type nxt_st;
   logic mem_we;
   logic [4:0] mem_addr;
   logic lc_pair;
   logic tier_pair;
   logic [7:0] cur_byte;
   logic [4:0] sum_idx;
   logic [4:0] last_idx;
   logic [4:0] nidx;
   logic [7:0] nsum;

   lach_resp_mem #(.WIDTH(8), .DEPTH(32), .AW(5)) u_mem (
      .core_clk(core_clk),
      .we(mem_we),
      .wr_addr(mem_addr),
      .wr_data(rx.data),
      .rd_addr(auth_rd_addr),
      .rd_data(auth_rd_data)
   );

   assign mem_addr = 5'(st_ff.cnt - 16'd1);
   assign mem_we = st_ff.phase == lach_pkg::st_body && rx.valid && st_ff.resp &&
                   st_ff.cnt >= 16'd1 && st_ff.cnt <= `LACH_RESP_BYTES;
   assign lc_pair = (st_ff.src == `LACH_LC_OWNER && st_ff.dst == `LACH_LC_RET_REQ) ||
                    (st_ff.src == `LACH_LC_RET_REQ && st_ff.dst == `LACH_LC_RET_ACK);
   assign tier_pair = (st_ff.src == `LACH_TIER_ZERO && st_ff.dst == `LACH_TIER_ONE) ||
                      (st_ff.src == `LACH_TIER_ONE && st_ff.dst == `LACH_TIER_TWO);
   assign sum_idx = st_ff.frame == lach_pkg::fr_chal ? `LACH_TX_CHAL_SUM : `LACH_TX_STS_SUM;
   assign last_idx = st_ff.frame == lach_pkg::fr_chal ? `LACH_TX_CHAL_LAST : `LACH_TX_STS_LAST;
   assign cur_byte = st_ff.tx_data;
   assign nidx = st_ff.idx + 5'd1;
   // running check over length-high to last payload byte
   assign nsum = (st_ff.idx >= 5'd1 && st_ff.idx < sum_idx) ? st_ff.tx_sum + cur_byte : st_ff.tx_sum; // see [R23]

   always_comb begin
      nxt_st = st_ff;
      nxt_st.gen_req = 1'b0;
      nxt_st.auth_req = 1'b0;
      nxt_st.trans_req = 1'b0;
      case (st_ff.phase)
         lach_pkg::st_idle: begin
            if (rx.valid && rx.data == (st_ff.resp ? `LACH_DATA_START : `LACH_CMD_START)) begin // see [R10] see [R21]
               nxt_st.phase = lach_pkg::st_len_h;
               nxt_st.sum = 8'h00;
               nxt_st.cnt = 16'd0;
            end
         end
         lach_pkg::st_len_h: begin
            if (rx.valid) begin
               nxt_st.len[15:8] = rx.data;
               nxt_st.sum = st_ff.sum + rx.data;
               nxt_st.phase = lach_pkg::st_len_l;
            end
         end
         lach_pkg::st_len_l: begin
            if (rx.valid) begin
               nxt_st.len[7:0] = rx.data;
               nxt_st.sum = st_ff.sum + rx.data;
               nxt_st.phase = {st_ff.len[15:8], rx.data} == 16'd0 ? lach_pkg::st_sum : lach_pkg::st_body;
            end
         end
         lach_pkg::st_body: begin
            if (rx.valid) begin
               nxt_st.sum = st_ff.sum + rx.data;
               nxt_st.cnt = st_ff.cnt + 16'd1;
               case (st_ff.cnt)
                  16'd0: nxt_st.code = rx.data;
                  16'd1: nxt_st.src = st_ff.resp ? st_ff.src : rx.data;
                  16'd2: nxt_st.dst = st_ff.resp ? st_ff.dst : rx.data;
                  16'd3: nxt_st.kind = st_ff.resp ? st_ff.kind : rx.data;
                  default: nxt_st.code = st_ff.code;
               endcase
               if (st_ff.cnt == st_ff.len - 16'd1) begin
                  nxt_st.phase = lach_pkg::st_sum;
               end
            end
         end
         lach_pkg::st_sum: begin
            if (rx.valid) begin
               nxt_st.sum = st_ff.sum + rx.data; // see [R23]
               nxt_st.phase = lach_pkg::st_end;
            end
         end
         lach_pkg::st_end: begin
            if (rx.valid) begin
               nxt_st.end_bad = rx.data != `LACH_FRAME_END;
               nxt_st.phase = lach_pkg::st_check;
            end
         end
         lach_pkg::st_check: begin
            nxt_st.phase = lach_pkg::st_tx;
            nxt_st.frame = lach_pkg::fr_err;
            nxt_st.after = lach_pkg::go_idle; // see [R14]
            nxt_st.resp = 1'b0;
            if (st_ff.end_bad) begin
               nxt_st.sts = `LACH_STS_PACKET; // see [R11]
            end else if (st_ff.sum != 8'h00) begin
               nxt_st.sts = `LACH_STS_CHECKSUM; // see [R12]
            end else if (st_ff.len == 16'd0) begin
               nxt_st.sts = `LACH_STS_PACKET; // see [R13]
            end else if (st_ff.resp) begin
               if (st_ff.code != `LACH_CODE_AUTH || st_ff.len != `LACH_LEN_RESP) begin
                  nxt_st.sts = `LACH_STS_PACKET; // see [R22]
               end else begin
                  nxt_st.phase = lach_pkg::st_auth;
                  nxt_st.auth_req = 1'b1;
               end
            end else if (st_ff.len != `LACH_LEN_CMD || st_ff.code != `LACH_CODE_AUTH) begin
               nxt_st.sts = `LACH_STS_PACKET; // see [R13]
            end else if (!dev.cmd_permitted || dev.enc_write_pending) begin
               nxt_st.sts = `LACH_STS_ACCEPT; // see [R15]
            end else if (dev.active_state != dev.stored_state) begin
               nxt_st.sts = `LACH_STS_UNMATCHED; // see [R16]
            end else if ((lc_pair && st_ff.src != dev.active_state) || (tier_pair && st_ff.src != dev.auth_tier)) begin
               nxt_st.sts = `LACH_STS_PARAM; // see [R17] see [R2]
            end else if (!lc_pair && !tier_pair) begin
               nxt_st.sts = `LACH_STS_PARAM; // see [R17] see [R3]
            end else if ((!dev.tier_two_key_en && (st_ff.dst == `LACH_LC_RET_REQ || st_ff.dst == `LACH_TIER_TWO)) ||
                         (!dev.tier_one_key_en && tier_pair && st_ff.dst == `LACH_TIER_ONE)) begin
               nxt_st.sts = `LACH_STS_PROTECT; // see [R18]
            end else if (!(st_ff.kind == `LACH_KIND_RANDOM ||
                           (st_ff.kind == `LACH_KIND_UID && st_ff.dst == `LACH_LC_RET_REQ))) begin
               nxt_st.sts = `LACH_STS_PARAM; // see [R19] see [R4]
            end else begin
               nxt_st.phase = lach_pkg::st_gen;
               nxt_st.lc_move = lc_pair;
               nxt_st.gen_req = 1'b1; // see [R20]
            end
            nxt_st.tx_data = `LACH_DATA_START;
            nxt_st.idx = 5'd0;
            nxt_st.tx_sum = 8'h00;
         end
         lach_pkg::st_gen: begin
            if (gen_done) begin
               nxt_st.phase = lach_pkg::st_tx;
               if (gen_fail) begin
                  nxt_st.sts = `LACH_STS_TRUSTED; // see [R20]
               end else begin
                  nxt_st.frame = lach_pkg::fr_chal;
                  nxt_st.after = lach_pkg::go_resp;
                  nxt_st.chal = gen_value;
               end
            end
         end
         lach_pkg::st_auth: begin
            if (auth_done) begin
               nxt_st.phase = lach_pkg::st_tx;
               if (auth_pass) begin
                  nxt_st.frame = lach_pkg::fr_ok;
                  nxt_st.sts = `LACH_STS_OK;
                  nxt_st.trans_req = 1'b1;
                  nxt_st.after = st_ff.lc_move ? lach_pkg::go_halt : lach_pkg::go_idle; // see [R25]
               end else begin
                  nxt_st.sts = `LACH_STS_TRUSTED; // see [R24]
               end
            end
         end
         lach_pkg::st_tx: begin
            if (tx_ready) begin
               nxt_st.tx_sum = nsum;
               if (st_ff.frame == lach_pkg::fr_chal && st_ff.idx >= `LACH_TX_PAY_FIRST && st_ff.idx < sum_idx) begin
                  nxt_st.chal = {st_ff.chal[119:0], 8'h00}; // see [R6]
               end
               nxt_st.idx = nidx;
               if (st_ff.idx == last_idx) begin
                  nxt_st.phase = st_ff.after == lach_pkg::go_halt ? lach_pkg::st_halt : lach_pkg::st_idle;
                  nxt_st.resp = st_ff.after == lach_pkg::go_resp;
               end else if (nidx == 5'd2) begin
                  nxt_st.tx_data = st_ff.frame == lach_pkg::fr_chal ? `LACH_LEN_CHAL : `LACH_LEN_STS; // see [R5]
               end else if (nidx == 5'd3) begin
                  nxt_st.tx_data = st_ff.frame == lach_pkg::fr_err ? `LACH_CODE_ERR : `LACH_CODE_AUTH; // see [R9]
               end else if (nidx == sum_idx) begin
                  nxt_st.tx_data = 8'h00 - nsum; // see [R23] see [R8]
               end else if (nidx == last_idx) begin
                  nxt_st.tx_data = `LACH_FRAME_END;
               end else if (st_ff.frame == lach_pkg::fr_chal && nidx >= `LACH_TX_PAY_FIRST) begin
                  nxt_st.tx_data = nxt_st.chal[127:120]; // see [R5]
               end else if (nidx == `LACH_TX_PAY_FIRST) begin
                  nxt_st.tx_data = st_ff.sts;
               end else if (nidx > `LACH_TX_PAY_FIRST) begin
                  nxt_st.tx_data = `LACH_UNUSED; // see [R8]
               end else begin
                  nxt_st.tx_data = 8'h00;
               end
            end
         end
         lach_pkg::st_halt: begin
            nxt_st.phase = lach_pkg::st_halt;
         end
         default: begin
            nxt_st.phase = lach_pkg::st_idle;
         end
      endcase
      if (ts_abnormal) begin
         nxt_st.phase = lach_pkg::st_halt; // see [R20]
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tx_valid = st_ff.phase == lach_pkg::st_tx;
   assign tx_data = st_ff.tx_data;
   assign gen_req = st_ff.gen_req;
   assign gen_uid = st_ff.kind == `LACH_KIND_UID;
   assign auth_req = st_ff.auth_req;
   assign trans_req = st_ff.trans_req;
   assign trans_lifecycle = st_ff.lc_move;
   assign trans_dst = st_ff.dst;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   idle_ignore_a: assert property ( // see [R10]
      st_ff.phase == lach_pkg::st_idle && !st_ff.resp && rx.valid && rx.data != `LACH_CMD_START && !ts_abnormal
      |=> st_ff.phase == lach_pkg::st_idle) else $error("idle left without command start byte");
   resp_discard_a: assert property ( // see [R21]
      st_ff.phase == lach_pkg::st_idle && st_ff.resp && rx.valid && rx.data != `LACH_DATA_START && !ts_abnormal
      |=> st_ff.phase == lach_pkg::st_idle && st_ff.resp) else $error("response wait left without data start");
   frame_start_a: assert property ( // see [R5]
      tx_valid && st_ff.idx == 5'd0 |-> tx_data == `LACH_DATA_START) else $error("frame does not open with 81h");
   chal_len_a: assert property ( // see [R5]
      tx_valid && st_ff.frame == lach_pkg::fr_chal && st_ff.idx == 5'd2 |-> tx_data == `LACH_LEN_CHAL)
      else $error("challenge length byte wrong");
   ok_sum_a: assert property ( // see [R8]
      tx_valid && st_ff.frame == lach_pkg::fr_ok && st_ff.idx == `LACH_TX_STS_SUM |-> tx_data == `LACH_OK_SUM)
      else $error("success check byte not ceh");
   err_code_a: assert property ( // see [R9]
      tx_valid && st_ff.frame == lach_pkg::fr_err && st_ff.idx == 5'd3 |-> tx_data == `LACH_CODE_ERR)
      else $error("error frame code not b0h");
   end_priority_a: assert property ( // see [R11]
      st_ff.phase == lach_pkg::st_check && st_ff.end_bad && !ts_abnormal
      |=> st_ff.sts == `LACH_STS_PACKET && st_ff.phase == lach_pkg::st_tx) else $error("missing end not packet error");
   sum_check_a: assert property ( // see [R12]
      st_ff.phase == lach_pkg::st_check && !st_ff.end_bad && st_ff.sum != 8'h00 && !ts_abnormal
      |=> st_ff.sts == `LACH_STS_CHECKSUM) else $error("bad check byte not reported");
   err_return_a: assert property ( // see [R14]
      tx_valid && st_ff.frame == lach_pkg::fr_err && st_ff.idx == `LACH_TX_STS_LAST && tx_ready && !ts_abnormal
      |=> st_ff.phase == lach_pkg::st_idle && !st_ff.resp && !trans_req) else $error("error did not return to wait");
   halt_stays_a: assert property ( // see [R20]
      ts_abnormal |=> st_ff.phase == lach_pkg::st_halt ##1 st_ff.phase == lach_pkg::st_halt && !tx_valid)
      else $error("abnormal subsystem still responding");
   lc_halt_a: assert property ( // see [R25]
      st_ff.phase == lach_pkg::st_auth && auth_done && auth_pass && st_ff.lc_move
      |=> trans_req ##[1:200] st_ff.phase == lach_pkg::st_halt) else $error("lifecycle move did not halt");

   chal_sent_c: cover property (tx_valid && tx_ready && st_ff.frame == lach_pkg::fr_chal && st_ff.idx == `LACH_TX_CHAL_LAST);
   ok_sent_c: cover property (tx_valid && tx_ready && st_ff.frame == lach_pkg::fr_ok && st_ff.idx == `LACH_TX_STS_LAST);
   err_sent_c: cover property (tx_valid && tx_ready && st_ff.frame == lach_pkg::fr_err && st_ff.idx == `LACH_TX_STS_LAST);
endmodule // lach_core

// ==== tb/lach_host.sv ====
`timescale 1ns/100ps
module lach_host (
   input wire logic core_clk,
   output lach_pkg::lach_byte_type rx,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   logic [7:0] send_q[$];
   logic [7:0] got_q[$];
   logic stall = 1'b0;
   logic [1:0] pace_ff = 2'h0;
   initial begin
      rx = '0;
      tx_ready = 1'b0;
   end
   // one byte a cycle; an idle line alternates the last byte with its complement
   always @(posedge core_clk) begin
      pace_ff <= pace_ff + 2'h1;
      if (send_q.size() > 0) begin
         rx <= '{valid: 1'b1, data: send_q.pop_front()};
      end else begin
         rx <= '{valid: 1'b0, data: ~rx.data};
      end
      if (tx_valid && tx_ready) begin
         got_q.push_back(tx_data);
      end
      tx_ready <= !stall || (pace_ff == 2'h3);
   end
endmodule // lach_host

// ==== tb/lifecycle_auth_command_handler_bench.sv ====
`timescale 1ns/100ps
module lifecycle_auth_command_handler_bench;
   localparam logic [127:0] CHAL = 128'h0123456789abcdef0011223344556677;
   localparam lach_pkg::lach_dev_type BASE = '{8'h04, 8'h04, 8'h04, 1'b1, 1'b0, 1'b1, 1'b1};
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   lach_pkg::lach_byte_type rx;
   lach_pkg::lach_dev_type dev = BASE;
   logic tx_ready, tx_valid, gen_req, gen_uid, auth_req, trans_req, trans_lifecycle;
   logic [7:0] tx_data, auth_rd_data, trans_dst, saw_dst;
   logic ts_abnormal = 1'b0;
   logic gen_done = 1'b0;
   logic auth_done = 1'b0;
   logic gen_fail = 1'b0;
   logic auth_pass = 1'b1;
   logic [4:0] auth_rd_addr = 5'h00;
   logic [3:0] gen_cnt = 4'h0;
   logic [3:0] auth_cnt = 4'h0;
   logic saw_uid, saw_lc;
   logic saw_trans = 1'b0;
   int gen_seen = 0;
   int fails = 0;
   int samples_checked = 0;
   always #2 core_clk = ~core_clk;
   lach_core i_dut (.core_clk(core_clk), .rst_b(rst_b), .rx(rx), .tx_ready(tx_ready), .tx_valid(tx_valid),
      .tx_data(tx_data), .dev(dev), .ts_abnormal(ts_abnormal), .gen_req(gen_req), .gen_uid(gen_uid),
      .gen_done(gen_done), .gen_fail(gen_fail), .gen_value(CHAL), .auth_req(auth_req), .auth_done(auth_done),
      .auth_pass(auth_pass), .auth_rd_addr(auth_rd_addr), .auth_rd_data(auth_rd_data), .trans_req(trans_req),
      .trans_lifecycle(trans_lifecycle), .trans_dst(trans_dst));
   lach_host i_host (.core_clk(core_clk), .rx(rx), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
   // trusted subsystem stand-in: answers four cycles after a request
   always @(posedge core_clk) begin
      gen_done <= gen_cnt == 4'h1;
      auth_done <= auth_cnt == 4'h1;
      gen_cnt <= gen_req ? 4'h3 : gen_cnt - {3'h0, gen_cnt != 4'h0};
      auth_cnt <= auth_req ? 4'h3 : auth_cnt - {3'h0, auth_cnt != 4'h0};
      if (gen_req) begin
         saw_uid <= gen_uid;
         gen_seen++;
      end
      if (trans_req) begin
         saw_trans <= 1'b1;
         saw_lc <= trans_lifecycle;
         saw_dst <= trans_dst;
      end
   end
   task automatic check(input string what, input logic [127:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   function automatic void tail(ref logic [7:0] f[$], input int from, input logic [7:0] adj, e);
      logic [7:0] s;
      s = 8'h00;
      for (int i = from; i < f.size(); i++) s = s + f[i];
      f.push_back(8'h00 - s + adj);
      f.push_back(e);
   endfunction
   task automatic send_cmd(input logic [7:0] c, l, s, d, k, a, e);
      logic [7:0] f[$];
      f = {8'h55, 8'h01, 8'h00, l}; // stray leading byte
      if (l != 8'h00) f = {f, c, s, d, k};
      tail(f, 2, a, e);
      foreach (f[i]) i_host.send_q.push_back(f[i]);
   endtask
   task automatic send_resp(input logic [7:0] c);
      logic [7:0] f[$];
      f = {8'h01, 8'h81, 8'h00, 8'h21, c}; // stray byte before start
      for (int i = 0; i < 32; i++) f.push_back(8'ha0 + 8'(i));
      tail(f, 2, 8'h00, 8'h03);
      foreach (f[i]) i_host.send_q.push_back(f[i]);
   endtask
   task automatic expect_frame(input logic [7:0] e[$]);
      int n;
      for (n = 0; n < 600 && i_host.got_q.size() < e.size(); n++) @(posedge core_clk);
      if (i_host.got_q.size() < e.size()) begin
         fails++;
         give_verdict();
      end
      repeat (4) @(posedge core_clk);
      check("frame size", i_host.got_q.size(), e.size());
      foreach (e[i]) check("frame byte", i_host.got_q[i], e[i]);
      i_host.got_q.delete();
   endtask
   task automatic expect_status(input logic [7:0] c, s);
      logic [7:0] e[$];
      e = {8'h81, 8'h00, 8'h0a, c, s};
      repeat (8) e.push_back(8'hff);
      tail(e, 1, 8'h00, 8'h03);
      expect_frame(e);
   endtask
   task automatic expect_chal();
      logic [7:0] e[$];
      e = {8'h81, 8'h00, 8'h11, 8'h30};
      for (int i = 15; i >= 0; i--) e.push_back(CHAL[i*8 +: 8]);
      tail(e, 1, 8'h00, 8'h03);
      expect_frame(e);
   endtask
   task automatic err(input logic [2:0] m, input logic [7:0] c, l, s, d, k, a, e, sts);
      lach_pkg::lach_dev_type v;
      v = BASE;
      case (m)
         3'h1: v.cmd_permitted = 1'b0;
         3'h2: v.enc_write_pending = 1'b1;
         3'h3: v.stored_state = 8'h07;
         3'h4: v.tier_two_key_en = 1'b0;
         3'h5: v.tier_one_key_en = 1'b0;
         default: v = BASE;
      endcase
      dev <= v;
      gen_fail <= m == 3'h6;
      send_cmd(c, l, s, d, k, a, e);
      expect_status(8'hb0, sts);
   endtask
   task automatic check_errors();
      err(3'h0, 8'h30, 8'h04, 8'h04, 8'h03, 8'h00, 8'h01, 8'h55, 8'hc1);
      err(3'h0, 8'h30, 8'h04, 8'h04, 8'h03, 8'h00, 8'h01, 8'h03, 8'hc2);
      err(3'h0, 8'h30, 8'h00, 8'h04, 8'h03, 8'h00, 8'h00, 8'h03, 8'hc1);
      err(3'h0, 8'h31, 8'h04, 8'h04, 8'h03, 8'h00, 8'h00, 8'h03, 8'hc1);
      err(3'h1, 8'h30, 8'h04, 8'h04, 8'h03, 8'h00, 8'h00, 8'h03, 8'hc3);
      err(3'h2, 8'h30, 8'h04, 8'h04, 8'h03, 8'h00, 8'h00, 8'h03, 8'hc3);
      err(3'h3, 8'h30, 8'h04, 8'h04, 8'h03, 8'h00, 8'h00, 8'h03, 8'hc4);
      err(3'h0, 8'h30, 8'h04, 8'h03, 8'h02, 8'h00, 8'h00, 8'h03, 8'hc5);
      err(3'h0, 8'h30, 8'h04, 8'h04, 8'h02, 8'h00, 8'h00, 8'h03, 8'hc5);
      err(3'h4, 8'h30, 8'h04, 8'h04, 8'h07, 8'h00, 8'h00, 8'h03, 8'hc6);
      err(3'h5, 8'h30, 8'h04, 8'h04, 8'h03, 8'h01, 8'h00, 8'h03, 8'hc6);
      err(3'h0, 8'h30, 8'h04, 8'h04, 8'h03, 8'h01, 8'h00, 8'h03, 8'hc5);
      check("requests after errors", gen_seen, 0);
      err(3'h6, 8'h30, 8'h04, 8'h04, 8'h03, 8'h00, 8'h00, 8'h03, 8'hc7);
      check("requests after fail", gen_seen, 1);
   endtask
   task automatic tier_move();
      dev <= BASE;
      gen_fail <= 1'b0;
      i_host.stall = 1'b1;
      send_cmd(8'h30, 8'h04, 8'h04, 8'h03, 8'h00, 8'h00, 8'h03);
      expect_chal();
      check("uid select", saw_uid, 1'b0);
      i_host.stall = 1'b0;
      send_resp(8'h30);
      expect_status(8'h30, 8'h00);
      check("tier move", {saw_trans, saw_lc, saw_dst}, {1'b1, 1'b0, 8'h03});
      auth_rd_addr <= 5'h00;
      repeat (2) @(posedge core_clk);
      check("first response byte", auth_rd_data, 8'ha0);
      auth_rd_addr <= 5'h1f;
      repeat (2) @(posedge core_clk);
      check("last response byte", auth_rd_data, 8'hbf);
   endtask
   task automatic lc_moves();
      send_cmd(8'h30, 8'h04, 8'h04, 8'h07, 8'h01, 8'h00, 8'h03);
      expect_chal();
      check("uid select", saw_uid, 1'b1);
      send_resp(8'h31);
      expect_status(8'hb0, 8'hc1);
      auth_pass <= 1'b0;
      send_cmd(8'h30, 8'h04, 8'h04, 8'h07, 8'h00, 8'h00, 8'h03);
      expect_chal();
      send_resp(8'h30);
      expect_status(8'hb0, 8'hc7);
      auth_pass <= 1'b1;
      saw_trans <= 1'b0;
      send_cmd(8'h30, 8'h04, 8'h04, 8'h07, 8'h00, 8'h00, 8'h03);
      expect_chal();
      send_resp(8'h30);
      expect_status(8'h30, 8'h00);
      check("lifecycle move", {saw_trans, saw_lc, saw_dst}, {1'b1, 1'b1, 8'h07});
      send_cmd(8'h30, 8'h04, 8'h04, 8'h03, 8'h00, 8'h00, 8'h03);
      repeat (80) @(posedge core_clk);
      check("silent after move", i_host.got_q.size(), 0);
   endtask
   task automatic abnormal_halt();
      rst_b <= 1'b0;
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      ts_abnormal <= 1'b1;
      @(posedge core_clk);
      ts_abnormal <= 1'b0;
      send_cmd(8'h30, 8'h04, 8'h04, 8'h03, 8'h00, 8'h00, 8'h03);
      repeat (80) @(posedge core_clk);
      check("silent when abnormal", i_host.got_q.size(), 0);
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      check("idle output", tx_valid, 1'b0);
      check_errors();
      tier_move();
      lc_moves();
      abnormal_halt();
      give_verdict();
   end
endmodule // lifecycle_auth_command_handler_bench
